// ===== rtl/adc_out_pkg.sv
// Constants shared by the converter output sequencing design
package adc_out_pkg;
	localparam int CFG_EDGE_OR_DEMUX_BIT = 8;
	localparam int CFG_OUTPUT_LEVEL_BIT = 9;
	localparam int CFG_DDR_DISABLE_BIT = 10;
	localparam int CFG_DDR_PHASE_BIT = 11;
	localparam int XCFG_DUAL_EDGE_BIT = 13;
	localparam int XCFG_Q_SELECT_BIT = 14;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] XCFG_RESET = 16'h0000;
	localparam logic [3:0] ADDR_CFG = 4'h1;
	localparam logic [3:0] ADDR_XCFG = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam int MAIN_LATENCY = 13;
	localparam int DELAYED_LATENCY = 14;
	localparam int SYNC_DELAY_DDR_DEMUX = 4;
	localparam int SYNC_DELAY_OTHER = 3;
	localparam int DUTY_MIN_PCT = 20;
	localparam int DUTY_MAX_PCT = 80;
	typedef enum logic [1:0] {
		PIN_LOW = 2'b00,
		PIN_HIGH = 2'b01,
		PIN_FLOAT = 2'b10
	} pin_level_e;
endpackage : adc_out_pkg

// ===== rtl/adc_output_demux_clocking.sv
// Output sequencing, demultiplexing and output clocking of a dual converter
`timescale 1ns/1ps
// What this block does
// - Range pin high picks full range, low reduced; same for both channels.
// - Dual-edge mode: one converter samples on rise, the other on fall.
// - Dual-edge with 1:2 demux spreads samples over all four buses.
// - Pin control allows only I input in dual-edge; registers pick I or Q.
// - Normal demux: main buses 13 cycles old, delayed buses 14.
// - Dual-edge demux: Q bus rise sample 13.5 old, delayed Q 14.5.
// - Non-demux mode holds both delayed buses in high impedance.
// - Non-demux: I bus 13 old; Q bus 13, or 13.5 in dual-edge.
// - SDR pin control: edge pin high gives rising, low falling edge.
// - Extended: edge/demux bit picks edge in SDR, demux in DDR.
// - DDR keeps data clock at 0 degree phase to data.
// - DDR with demux inserts four cycles sync delay, else three.
// - SDR data clock runs at the per-bus data rate.
// - DDR data clock runs at half data rate, data on both edges.
// - Pin control: floating edge pin selects DDR; high or low selects SDR.
// - Duty-corrected receiver on by default, tolerates 20/80 duty.
// - Demux halves each bus rate; non-demux runs at sample rate.
// - Config register bits 8 edge/demux, 9 level, 10 DDR off; bit 11 (phase) is stored but has no effect.
// - Extended config bit 13 enables dual-edge sampling.
module adc_output_demux_clocking #(
	parameter int W = 8
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic SAMPLE_CLK,
	input wire logic [W-1:0] I_SAMPLE,
	input wire logic [W-1:0] Q_SAMPLE,
	input wire logic RANGE_SELECT,
	input wire logic [1:0] OUTPUT_EDGE_SELECT,
	input wire logic DUAL_EDGE_PIN,
	input wire logic EXTENDED_MODE,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	output logic FULL_RANGE,
	output logic OUTPUT_LEVEL,
	output logic DUTY_CORRECT_EN,
	output logic OUTPUT_DATA_CLOCK,
	output logic [W-1:0] I_BUS_MAIN,
	output logic [W-1:0] Q_BUS_MAIN,
	output logic [W-1:0] I_BUS_DELAYED,
	output logic [W-1:0] Q_BUS_DELAYED,
	output logic DELAYED_OE_N
);
	logic [2:0] sclk_sync_ff;
	logic [1:0] range_sync_ff;
	logic [3:0] edge_sync_ff;
	logic [1:0] des_sync_ff;
	logic [1:0] ext_sync_ff;
	logic [15:0] cfg_ff;
	logic [15:0] xcfg_ff;
	logic [15:0] nxt_rdata;
	logic rise_ev;
	logic fall_ev;
	logic ext;
	logic range_s;
	logic [1:0] edge_s;
	logic des_pin_s;
	logic dual_edge;
	logic use_q;
	logic ddr;
	logic demux;
	logic sdr_rising;
	logic phase_ff;
	logic [2:0] sync_cnt_ff;
	logic [2:0] sync_target;
	logic started_ff;
	logic [W-1:0] rise_smp_ff;
	logic [W-1:0] sel_in;
	logic [W-1:0] nxt_i_main;
	logic [W-1:0] nxt_q_main;
	logic output_data_clock_ff;
	logic update;

	sample_delay_if #(.W(W)) dif ();
	sample_delay_line #(.W(W), .DEPTH(adc_out_pkg::DELAYED_LATENCY)) u_line (
		.clk(CORE_CLK),
		.rst(RST),
		.dl(dif)
	);

	// Two-flop synchronisers for all pin inputs; third stage is edge history
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sclk_sync_ff <= 3'h0;
			range_sync_ff <= 2'h0;
			edge_sync_ff <= 4'h0;
			des_sync_ff <= 2'h0;
			ext_sync_ff <= 2'h0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], SAMPLE_CLK};
			range_sync_ff <= {range_sync_ff[0], RANGE_SELECT};
			edge_sync_ff <= {edge_sync_ff[1:0], OUTPUT_EDGE_SELECT};
			des_sync_ff <= {des_sync_ff[0], DUAL_EDGE_PIN};
			ext_sync_ff <= {ext_sync_ff[0], EXTENDED_MODE};
		end
	end
	assign rise_ev = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign fall_ev = ~sclk_sync_ff[1] & sclk_sync_ff[2];
	assign ext = ext_sync_ff[1];
	assign range_s = range_sync_ff[1];
	assign edge_s = edge_sync_ff[3:2];
	assign des_pin_s = des_sync_ff[1];

	// Register port, read data one cycle after the strobe
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cfg_ff <= adc_out_pkg::CFG_RESET;
			xcfg_ff <= adc_out_pkg::XCFG_RESET;
		end else if (WR) begin
			if (ADDR == adc_out_pkg::ADDR_CFG)
				cfg_ff <= WDATA;
			if (ADDR == adc_out_pkg::ADDR_XCFG)
				xcfg_ff <= WDATA;
		end
	end
	always_comb begin
		nxt_rdata = 16'h0000;
		unique case (ADDR)
			adc_out_pkg::ADDR_CFG: nxt_rdata = cfg_ff;
			adc_out_pkg::ADDR_XCFG: nxt_rdata = xcfg_ff;
			adc_out_pkg::ADDR_STATUS:
				nxt_rdata = {10'h000, started_ff, ext, ddr, demux,
					dual_edge, use_q};
			default: nxt_rdata = 16'h0000;
		endcase
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			RDATA <= 16'h0000;
		else if (RD)
			RDATA <= nxt_rdata;
		else
			RDATA <= 16'h0000;
	end

	// Mode decode from pins or from the configuration registers
	assign dual_edge = ext ? xcfg_ff[adc_out_pkg::XCFG_DUAL_EDGE_BIT]
		: des_pin_s;
	assign use_q = ext & xcfg_ff[adc_out_pkg::XCFG_Q_SELECT_BIT];
	always_comb begin
		if (ext) begin
			ddr = ~cfg_ff[adc_out_pkg::CFG_DDR_DISABLE_BIT];
			demux = ddr ? cfg_ff[adc_out_pkg::CFG_EDGE_OR_DEMUX_BIT]
				: 1'b1;
			sdr_rising = cfg_ff[adc_out_pkg::CFG_EDGE_OR_DEMUX_BIT];
		end else begin
			ddr = (edge_s == adc_out_pkg::PIN_FLOAT);
			demux = 1'b1;
			sdr_rising = (edge_s == adc_out_pkg::PIN_HIGH);
		end
	end
	assign FULL_RANGE = range_s;
	assign OUTPUT_LEVEL = ext ? cfg_ff[adc_out_pkg::CFG_OUTPUT_LEVEL_BIT]
		: 1'b1;
	assign DUTY_CORRECT_EN = 1'b1;
	assign DELAYED_OE_N = ~demux;
	assign sel_in = use_q ? Q_SAMPLE : I_SAMPLE;

	// Rise-edge sample held for the following fall, giving the half cycle
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			rise_smp_ff <= '0;
		else if (rise_ev)
			rise_smp_ff <= sel_in;
	end
	assign dif.shift = fall_ev;
	assign dif.rise_in = rise_smp_ff;
	assign dif.fall_i_in = dual_edge ? sel_in : I_SAMPLE;
	assign dif.fall_q_in = Q_SAMPLE;

	// Startup sync delay: four cycles for DDR demux, three otherwise
	assign sync_target = (ddr && demux)
		? 3'(adc_out_pkg::SYNC_DELAY_DDR_DEMUX)
		: 3'(adc_out_pkg::SYNC_DELAY_OTHER);
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sync_cnt_ff <= 3'h0;
			started_ff <= 1'b0;
		end else if (fall_ev && !started_ff) begin
			sync_cnt_ff <= sync_cnt_ff + 3'h1;
			if (sync_cnt_ff + 3'h1 >= sync_target)
				started_ff <= 1'b1;
		end
	end

	// Demux phase: buses update on every other fall when demultiplexed
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			phase_ff <= 1'b0;
		else if (fall_ev)
			phase_ff <= ~phase_ff;
	end
	assign update = fall_ev & started_ff & (~demux | phase_ff);

	always_comb begin
		nxt_i_main = dif.fi_tap13;
		nxt_q_main = dual_edge ? dif.rise_tap13 : dif.fq_tap13;
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			I_BUS_MAIN <= '0;
			Q_BUS_MAIN <= '0;
			I_BUS_DELAYED <= '0;
			Q_BUS_DELAYED <= '0;
		end else if (update) begin
			I_BUS_MAIN <= nxt_i_main;
			Q_BUS_MAIN <= nxt_q_main;
			I_BUS_DELAYED <= demux ? dif.fi_tap14 : '0;
			Q_BUS_DELAYED <= demux ? (dual_edge ? dif.rise_tap14
				: dif.fq_tap14) : '0;
		end
	end

	// Output data clock: SDR rises on the fall between updates and drops on each update so data moves on one edge;
	// DDR toggles once per update so both edges carry data at 0 degrees
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			output_data_clock_ff <= 1'b0;
		else if (ddr && update)
			output_data_clock_ff <= ~output_data_clock_ff;
		else if (!ddr && fall_ev && started_ff && (!demux || !phase_ff))
			output_data_clock_ff <= 1'b1;
		else if (!ddr && update)
			output_data_clock_ff <= 1'b0;
	end
	assign OUTPUT_DATA_CLOCK = ddr ? output_data_clock_ff
		: (sdr_rising ? ~output_data_clock_ff : output_data_clock_ff);

	a_delayed_hiz: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(update && !demux) |=> DELAYED_OE_N && I_BUS_DELAYED == '0
			&& Q_BUS_DELAYED == '0)
		else $error("delayed buses driven");
	a_range_follow: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		FULL_RANGE == $past(range_sync_ff[0]))
		else $error("range wrong");
	a_pin_i_only: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(!ext && rise_ev) |=> rise_smp_ff == $past(I_SAMPLE))
		else $error("Q chosen under pin control");
	a_ddr_float: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(!ext && edge_s == adc_out_pkg::PIN_FLOAT) |-> ddr)
		else $error("float not DDR");
	a_ext_des: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		ext |-> dual_edge == xcfg_ff[adc_out_pkg::XCFG_DUAL_EDGE_BIT])
		else $error("dual-edge bit");
	a_ext_ddr: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		ext |-> ddr == !cfg_ff[adc_out_pkg::CFG_DDR_DISABLE_BIT])
		else $error("DDR disable bit");
	a_i_update: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		update |=> I_BUS_MAIN == $past(dif.fi_tap13))
		else $error("I bus latency");
	a_q_des: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(update && dual_edge) |=> Q_BUS_MAIN == $past(dif.rise_tap13))
		else $error("Q bus dual-edge latency");
	a_ddr_toggle: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		(update && ddr) |=> output_data_clock_ff != $past(output_data_clock_ff))
		else $error("DDR clock not toggling");
	a_duty_on: assert property (
		@(posedge CORE_CLK) disable iff (RST)
		DUTY_CORRECT_EN)
		else $error("duty correction off");
endmodule : adc_output_demux_clocking

// ===== rtl/sample_delay_if.sv
// Signals between the sequencer and its sample delay line
`timescale 1ns/1ps
interface sample_delay_if #(parameter int W = 8);
	logic shift;
	logic [W-1:0] rise_in;
	logic [W-1:0] fall_i_in;
	logic [W-1:0] fall_q_in;
	logic [W-1:0] rise_tap13;
	logic [W-1:0] rise_tap14;
	logic [W-1:0] fi_tap13;
	logic [W-1:0] fi_tap14;
	logic [W-1:0] fq_tap13;
	logic [W-1:0] fq_tap14;
	modport ctrl (output shift, rise_in, fall_i_in, fall_q_in,
		input rise_tap13, rise_tap14, fi_tap13, fi_tap14, fq_tap13, fq_tap14);
	modport line (input shift, rise_in, fall_i_in, fall_q_in,
		output rise_tap13, rise_tap14, fi_tap13, fi_tap14, fq_tap13, fq_tap14);
endinterface : sample_delay_if

// ===== rtl/sample_delay_line.sv
// Pipeline memory holding converted samples per input clock cycle
`timescale 1ns/1ps
module sample_delay_line #(
	parameter int W = 8,
	parameter int DEPTH = 14
) (
	input wire logic clk,
	input wire logic rst,
	sample_delay_if.line dl
);
	logic [W-1:0] rise_ff [DEPTH];
	logic [W-1:0] fi_ff [DEPTH];
	logic [W-1:0] fq_ff [DEPTH];
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : stage
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					rise_ff[g] <= '0;
					fi_ff[g] <= '0;
					fq_ff[g] <= '0;
				end else if (dl.shift) begin
					rise_ff[g] <= (g == 0) ? dl.rise_in : rise_ff[(g == 0) ? 0 : g-1];
					fi_ff[g] <= (g == 0) ? dl.fall_i_in : fi_ff[(g == 0) ? 0 : g-1];
					fq_ff[g] <= (g == 0) ? dl.fall_q_in : fq_ff[(g == 0) ? 0 : g-1];
				end
			end
		end
	endgenerate
	assign dl.rise_tap13 = rise_ff[DEPTH-2];
	assign dl.rise_tap14 = rise_ff[DEPTH-1];
	assign dl.fi_tap13 = fi_ff[DEPTH-2];
	assign dl.fi_tap14 = fi_ff[DEPTH-1];
	assign dl.fq_tap13 = fq_ff[DEPTH-2];
	assign dl.fq_tap14 = fq_ff[DEPTH-1];
endmodule : sample_delay_line

// ===== tb/adc_output_demux_clocking_test.sv
// Self-checking bench for the converter output sequencer
`timescale 1ns/1ps
module adc_output_demux_clocking_test;
	typedef struct {
		logic [7:0] ri;
		logic [7:0] rq;
		logic [7:0] fi;
		logic [7:0] fq;
	} note_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk = 1'b0;
	logic [7:0] i_smp = 8'h00;
	logic [7:0] q_smp = 8'h00;
	logic rng = 1'b0;
	logic [1:0] es = 2'b01;
	logic dp = 1'b0;
	logic ext = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wd = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic full_range, out_level, duty_en, output_data_clock, oe_n, got;
	logic [7:0] ib, qb, idb, qdb, lri, lrq;
	logic [31:0] grp;
	logic des = 1'b0, usq = 1'b0, dmx = 1'b1, rd_d = 1'b0, output_data_clock_q = 1'b0;
	logic sdr = 1'b1, lvl = 1'b1;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int falls = 0;
	int rises = 0;
	logic [31:0] seed = 32'h0000_0016;
	note_s notes[$];
	logic [15:0] rd_exp[$];
	adc_output_demux_clocking #(.W(8)) i_dut (.CORE_CLK(clk), .RST(rst),
		.SAMPLE_CLK(sclk), .I_SAMPLE(i_smp), .Q_SAMPLE(q_smp),
		.RANGE_SELECT(rng), .OUTPUT_EDGE_SELECT(es), .DUAL_EDGE_PIN(dp),
		.EXTENDED_MODE(ext), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
		.RDATA(rdata), .FULL_RANGE(full_range), .OUTPUT_LEVEL(out_level),
		.DUTY_CORRECT_EN(duty_en), .OUTPUT_DATA_CLOCK(output_data_clock),
		.I_BUS_MAIN(ib), .Q_BUS_MAIN(qb), .I_BUS_DELAYED(idb),
		.Q_BUS_DELAYED(qdb), .DELAYED_OE_N(oe_n));
	rx_model #(.W(8)) i_rx (.clk(clk), .demux(dmx), .i_main(ib),
		.q_main(qb), .i_dly(idb), .q_dly(qdb), .got(got), .grp(grp));
	always #20 clk = ~clk;
	initial begin
		#7;
		forever #160 sclk = ~sclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] exp_grp(input note_s a, input note_s b);
		if (!des)
			return dmx ? {a.fq, a.fi, b.fq, b.fi} : {16'h0000, b.fq, b.fi};
		if (usq)
			return dmx ? {a.rq, a.fq, b.rq, b.fq} : {16'h0000, b.rq, b.fq};
		return dmx ? {a.ri, a.fi, b.ri, b.fi} : {16'h0000, b.ri, b.fi};
	endfunction : exp_grp
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// Each edge gets a fresh value, held across its detection window
	always @(sclk) begin
		@(posedge clk);
		seed = xs(seed);
		i_smp <= seed[7:0];
		q_smp <= seed[15:8];
		if (sclk) begin
			lri = seed[7:0];
			lrq = seed[15:8];
		end else if (!rst) begin
			notes.push_back('{lri, lrq, seed[7:0], seed[15:8]});
			falls++;
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	always @(negedge clk) begin
		if (output_data_clock === 1'b1 && output_data_clock_q === 1'b0)
			rises++;
		output_data_clock_q = output_data_clock;
		if (rd_d)
			chk("rdata", rd_exp.pop_front(), rdata);
		rd_d = rd;
		if (got === 1'b1 && falls >= 15) begin
			while (notes.size() > 15)
				void'(notes.pop_front());
			chk("bus_group", exp_grp(notes[0], notes[1]), grp);
			if (sdr)
				chk("output_data_clock_edge", lvl, output_data_clock);
		end
	end
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [15:0] d);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		if (!w)
			rd_exp.push_back(d);
		@(posedge clk);
	endtask : bus
	task automatic idle();
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask : idle
	// Status read a few cycles after the n-th fall has been detected
	task automatic status_at(input int n, input logic [15:0] e);
		while (falls < n)
			@(posedge clk);
		repeat (4) @(posedge clk);
		bus(1'b0, adc_out_pkg::ADDR_STATUS, e);
		idle();
	endtask : status_at
	task automatic start(input logic [1:0] e, input logic p, input logic x,
		input logic [15:0] cfg, input logic [15:0] xc);
		falls = 0;
		rst <= 1'b1;
		es <= e;
		dp <= p;
		ext <= x;
		repeat (5) @(posedge clk);
		@(posedge sclk);
		@(posedge clk);
		rst <= 1'b0;
		notes.delete();
		falls = 0;
		if (x) begin
			bus(1'b1, adc_out_pkg::ADDR_CFG, cfg);
			bus(1'b1, adc_out_pkg::ADDR_XCFG, xc);
		end
	endtask : start
	task automatic rate(input int e);
		while (falls < 20)
			@(posedge clk);
		rises = 0;
		while (falls < 36)
			@(posedge clk);
		chk("output_data_clock_rate", 1, rises >= e - 1 && rises <= e + 1);
	endtask : rate
	initial begin
		rng <= 1'b1;
		start(2'b01, 1'b0, 1'b0, 16'h0000, 16'h0000);
		repeat (3) idle();
		chk("duty_en", 1, duty_en);
		chk("full_range", 1, full_range);
		chk("out_level", 1, out_level);
		chk("oe_n", 0, oe_n);
		status_at(3, 16'h0024);
		rate(8);
		rng <= 1'b0;
		start(2'b10, 1'b1, 1'b0, 16'h0000, 16'h0000);
		repeat (3) idle();
		des = 1'b1;
		sdr = 1'b0;
		chk("full_range", 0, full_range);
		rate(4);
		start(2'b00, 1'b0, 1'b1, 16'h0b00, 16'h6000);
		usq = 1'b1;
		bus(1'b0, adc_out_pkg::ADDR_CFG, 16'h0b00);
		bus(1'b0, adc_out_pkg::ADDR_XCFG, 16'h6000);
		bus(1'b0, 4'h5, 16'h0000);
		bus(1'b1, 4'h5, 16'hffff);
		bus(1'b0, 4'h5, 16'h0000);
		idle();
		chk("out_level", 1, out_level);
		chk("oe_n", 0, oe_n);
		status_at(3, 16'h001f);
		status_at(4, 16'h003f);
		rate(4);
		start(2'b00, 1'b0, 1'b1, 16'h0000, 16'h0000);
		idle();
		{des, usq, dmx} = 3'b000;
		chk("out_level", 0, out_level);
		chk("oe_n", 1, oe_n);
		rate(8);
		start(2'b00, 1'b0, 1'b1, 16'h0000, 16'h2000);
		idle();
		des = 1'b1;
		rate(8);
		start(2'b00, 1'b0, 1'b0, 16'h0000, 16'h0000);
		idle();
		{des, usq, dmx, sdr, lvl} = 5'b00110;
		rate(8);
		tally_and_finish();
	end
endmodule : adc_output_demux_clocking_test

// ===== tb/rx_model.sv
// Receiver model that regroups parallel bytes into time order
`timescale 1ns/1ps
module rx_model #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic demux,
	input wire logic [W-1:0] i_main,
	input wire logic [W-1:0] q_main,
	input wire logic [W-1:0] i_dly,
	input wire logic [W-1:0] q_dly,
	output logic got,
	output logic [4*W-1:0] grp
);
	logic [4*W-1:0] cur;
	logic [4*W-1:0] last_ff;
	// Earliest first: delayed Q, delayed I, Q, I; or Q then I
	assign cur = demux ? {q_dly, i_dly, q_main, i_main}
		: {{(2*W){1'b0}}, q_main, i_main};
	always_ff @(posedge clk) begin
		got <= (cur !== last_ff);
		grp <= cur;
		last_ff <= cur;
	end
endmodule : rx_model
